/* hdl/radio_cmd_defs.vh */
`ifndef RADIO_CMD_DEFS_VH
`define RADIO_CMD_DEFS_VH
// ==========================================
// Command prefixes
`define SETUP_PREFIX      3'h4
`define TUNING_PREFIX     4'ha
`define WAKEUP_PREFIX     3'h7
`define LEVEL_PREFIX      4'hb
`define STATUS_CMD        8'hcc
`define POWER_CMD         8'hc0
`define THRESHOLD_CMD     8'hc2
`define SLEEP_CMD         8'hc4
`define SEND_CMD          8'hc6
`define RATE_CMD          8'hc8
`define KEYS_CMD          8'hca
// ==========================================
// Power-on values
`define SETUP_RST         16'h8080
`define LEVEL_RST         8'hb0
`define TUNING_RST        16'ha7d0
`define RATE_RST          16'hc800
`define KEYS_RST          16'hca00
`define SLEEP_RST         16'hc400
`define WAKEUP_RST        16'he000
`define THRESHOLD_RST     16'hc200
`define POWER_RST         16'hc000
// ==========================================
// Field positions
`define BAND_HI           12
`define BAND_LO           11
`define CLKDIV_HI         10
`define CLKDIV_LO         8
`define TRIM_HI           7
`define TRIM_LO           4
`define POLARITY_BIT      3
`define DEV_HI            2
`define DEV_LO            0
`define OOK_BIT           3
`define PWR_HI            2
`define PWR_LO            0
`define PA_EN_BIT         3
`define TX0_BIT           6
`define HOSTCLK_EN_BIT    0
// ==========================================
// Value scaling
`define TRIM_BASE_HALFPF  6'h11
`define DEV_STEP_KHZ      8'h1e
`define PWR_STEP_DB       5'h03
`define DEV_UNUSED        3'h7
`define TUNING_MIN        12'h060
`define TUNING_MAX        12'hf3f
`define STATUS_BITS       5'h10
// Host clock periods in 100 ns cycles of the 10 MHz clock
`define HCLK_DIV0         4'ha
`define HCLK_DIV1         4'h8
`define HCLK_DIV2         4'h6
`define HCLK_DIV3         4'h5
`define HCLK_DIV4         4'h4
`define HCLK_DIV5         4'h3
`define HCLK_DIV6         4'h2
`define HCLK_DIV7         4'h1
`endif

/* hdl/pin_sync.v */
`timescale 1ns/10ps
// ==========================================
// Two-stage synchroniser, one per pin
module pin_sync #(
  parameter WIDTH = 5
) (
  input  wire             sys_clk,
  input  wire             sys_rst,
  input  wire [WIDTH-1:0] pin_in,
  input  wire [WIDTH-1:0] rst_val,
  output wire [WIDTH-1:0] pin_out
);
  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
      reg meta;
      reg stable;
      // First stage feeds only the second
      // Stored relative to the idle level, so a cleared stage reads as idle
      always @(posedge sys_clk) begin
        if (sys_rst) begin
          meta   <= 1'b0;
          stable <= 1'b0;
        end else begin
          meta   <= pin_in[i] ^ rst_val[i];
          stable <= meta;
        end
      end
      assign pin_out[i] = stable ^ rst_val[i];
    end
  endgenerate
endmodule // pin_sync

/* hdl/host_clock_div.v */
`timescale 1ns/10ps
`include "radio_cmd_defs.vh"
// ==========================================
// Host clock rate enable
module host_clock_div (
  input  wire       sys_clk,
  input  wire       sys_rst,
  input  wire       enable,
  input  wire [2:0] rate_code,
  output reg        tick
);
  reg [3:0] period;
  reg [3:0] count;

  always @* begin
    case (rate_code)
      3'h0:    period = `HCLK_DIV0;
      3'h1:    period = `HCLK_DIV1;
      3'h2:    period = `HCLK_DIV2;
      3'h3:    period = `HCLK_DIV3;
      3'h4:    period = `HCLK_DIV4;
      3'h5:    period = `HCLK_DIV5;
      3'h6:    period = `HCLK_DIV6;
      default: period = `HCLK_DIV7;
    endcase
  end

  // One pulse per host clock period; a new code applies at once to the period already counting
  always @(posedge sys_clk) begin
    if (sys_rst || !enable) begin
      count <= 4'h0;
      tick  <= 1'b0;
    end else if (count >= period - 4'h1) begin
      count <= 4'h0;
      tick  <= 1'b1;
    end else begin
      count <= count + 4'h1;
      tick  <= 1'b0;
    end
  end
endmodule // host_clock_div

/* hdl/command_registers.v */
`timescale 1ns/10ps
`include "radio_cmd_defs.vh"
module command_registers (
  input  wire        sys_clk,
  input  wire        sys_rst,
  input  wire        select_n,
  input  wire        serial_clock,
  input  wire        serial_data,
  input  wire        modulation_pin,
  input  wire        key_n,
  input  wire        supply_low,
  output reg         interrupt_request_n,
  output reg  [15:0] radio_setup,
  output reg  [7:0]  amplifier_level,
  output reg  [15:0] channel_tuning,
  output reg  [15:0] symbol_rate,
  output reg  [15:0] key_inputs,
  output reg  [15:0] sleep_clock_command,
  output reg  [15:0] periodic_wakeup,
  output reg  [15:0] supply_threshold,
  output reg  [15:0] power_control,
  output reg         transmit_start,
  output reg  [9:0]  band_mhz,
  output reg         host_clock_tick,
  output reg  [5:0]  crystal_trim_halfpf,
  output reg  [7:0]  deviation_khz,
  output reg  [4:0]  attenuation_db,
  output reg         channel_high,
  output reg         amplifier_on
);
  // ==========================================
  // Pin synchronisers
  wire [4:0] synced;
  wire       sel_n_s;
  wire       sck_s;
  wire       sdi_s;
  wire       mod_s;
  wire       key_n_s;
  wire       low_s;

  pin_sync #(
    .WIDTH (5)
  ) u_sync (
    .sys_clk (sys_clk),
    .sys_rst (sys_rst),
    .pin_in  ({select_n, serial_clock, serial_data, modulation_pin, key_n}),
    .rst_val (5'h11),
    .pin_out (synced)
  );

  // Select and key idle high; the sync stage leaves reset at that level, so no false edge
  assign sel_n_s = synced[4];
  assign sck_s   = synced[3];
  assign sdi_s   = synced[2];
  assign mod_s   = synced[1];
  assign key_n_s = synced[0];

  reg low_meta;
  reg low_q;
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      low_meta <= 1'b0;
      low_q    <= 1'b0;
    end else begin
      low_meta <= supply_low;
      low_q    <= low_meta;
    end
  end
  assign low_s = low_q;

  // ==========================================
  // Edge detection on synchronised levels
  reg sck_d;
  reg key_d;
  reg low_d;
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      sck_d <= 1'b0;
      key_d <= 1'b1;
      low_d <= 1'b0;
    end else begin
      sck_d <= sck_s;
      key_d <= key_n_s;
      low_d <= low_s;
    end
  end

  wire active   = ~sel_n_s;
  wire sck_rise = active & sck_s & ~sck_d;
  wire sck_fall = active & ~sck_s & sck_d;
  wire key_ev   = key_d & ~key_n_s;
  wire low_ev   = low_s & ~low_d;

  // ==========================================
  // Command shifter, MSB first
  reg  [14:0] shift;
  reg  [3:0]  bit_cnt;
  reg         status_mode;
  wire [15:0] word = {shift, sdi_s};
  wire        byte_done = sck_rise & (bit_cnt == 4'h7) & ~status_mode;
  wire        word_done = sck_rise & (bit_cnt == 4'hf) & ~status_mode;
  wire        is_status = byte_done & (word[7:0] == `STATUS_CMD);
  wire        is_level  = byte_done & (word[7:4] == `LEVEL_PREFIX);

  always @(posedge sys_clk) begin
    if (sys_rst || !active) begin
      shift   <= 15'h0000;
      bit_cnt <= 4'h0;
    end else if (sck_rise) begin
      shift <= word[14:0];
      if (is_status || is_level) begin
        bit_cnt <= 4'h0;
      end else begin
        bit_cnt <= bit_cnt + 4'h1;
      end
    end
  end

  // ==========================================
  // Register writes
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      radio_setup         <= `SETUP_RST;
      amplifier_level     <= `LEVEL_RST;
      channel_tuning      <= `TUNING_RST;
      symbol_rate         <= `RATE_RST;
      key_inputs          <= `KEYS_RST;
      sleep_clock_command <= `SLEEP_RST;
      periodic_wakeup     <= `WAKEUP_RST;
      supply_threshold    <= `THRESHOLD_RST;
      power_control       <= `POWER_RST;
      transmit_start      <= 1'b0;
    end else begin
      transmit_start <= 1'b0;
      if (is_level) begin
        amplifier_level <= word[7:0];
      end
      if (word_done) begin
        if (word[15:13] == `SETUP_PREFIX) begin
          radio_setup <= word;
        end else if (word[15:12] == `TUNING_PREFIX) begin
          // Out-of-range channel words keep the previous setting
          if (word[11:0] >= `TUNING_MIN && word[11:0] <= `TUNING_MAX) begin
            channel_tuning <= word;
          end
        end else if (word[15:13] == `WAKEUP_PREFIX) begin
          periodic_wakeup <= word;
        end else begin
          case (word[15:8])
            `POWER_CMD:     power_control       <= word;
            `THRESHOLD_CMD: supply_threshold    <= word;
            `SLEEP_CMD:     sleep_clock_command <= word;
            `RATE_CMD:      symbol_rate         <= word;
            `KEYS_CMD:      key_inputs          <= word;
            `SEND_CMD:      transmit_start      <= 1'b1;
            default:        transmit_start      <= 1'b0;
          endcase
        end
      end
    end
  end

  // ==========================================
  // Interrupt sources
  reg  por_flag;
  reg  low_flag;
  reg  key_flag;
  wire any_pending = por_flag | low_flag | key_flag;
  // Retire the source currently reported, highest priority first
  wire clr_por = is_status & por_flag;
  wire clr_low = is_status & ~por_flag & low_flag;
  wire clr_key = is_status & ~por_flag & ~low_flag & key_flag;

  // A new event in the retire cycle survives: set beats clear
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      por_flag <= 1'b1;
      low_flag <= 1'b0;
      key_flag <= 1'b0;
    end else begin
      por_flag <= por_flag & ~clr_por;
      low_flag <= (low_flag & ~clr_low) | low_ev;
      key_flag <= (key_flag & ~clr_key) | key_ev;
    end
  end

  // ==========================================
  // Status readout on the interrupt pin
  reg [15:0] status_shift;
  always @(posedge sys_clk) begin
    if (sys_rst || !active) begin
      status_mode  <= 1'b0;
      status_shift <= 16'h0000;
    end else if (is_status) begin
      status_mode  <= 1'b1;
      status_shift <= {por_flag, any_pending, low_flag, key_flag, 12'h000};
    end else if (status_mode && sck_fall) begin
      status_shift <= {status_shift[14:0], 1'b0};
    end
  end

  // Pin is low while any source waits; in readout it carries data
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      interrupt_request_n <= 1'b1;
    end else if (is_status) begin
      interrupt_request_n <= por_flag;
    end else if (status_mode) begin
      if (sck_fall) begin
        interrupt_request_n <= status_shift[14];
      end
    end else begin
      interrupt_request_n <= ~any_pending;
    end
  end

  // ==========================================
  // Field decode
  wire [1:0] band_code = radio_setup[`BAND_HI:`BAND_LO];
  wire [3:0] trim_code = radio_setup[`TRIM_HI:`TRIM_LO];
  wire [2:0] dev_code  = radio_setup[`DEV_HI:`DEV_LO];
  wire [2:0] pwr_code  = amplifier_level[`PWR_HI:`PWR_LO];
  wire       ook_mode  = amplifier_level[`OOK_BIT];
  wire       pa_enable = power_control[`PA_EN_BIT] | power_control[`TX0_BIT];
  wire [7:0] dev_mult  = {5'h00, dev_code} + 8'h01;
  wire [15:0] dev_prod = dev_mult * `DEV_STEP_KHZ;
  wire [9:0]  pwr_prod = {7'h00, pwr_code} * `PWR_STEP_DB;

  always @(posedge sys_clk) begin
    if (sys_rst) begin
      band_mhz            <= 10'h000;
      crystal_trim_halfpf <= 6'h00;
      deviation_khz       <= 8'h00;
      attenuation_db      <= 5'h00;
      channel_high        <= 1'b0;
      amplifier_on        <= 1'b0;
    end else begin
      case (band_code)
        2'h0:    band_mhz <= 10'h13b;
        2'h1:    band_mhz <= 10'h1b1;
        2'h2:    band_mhz <= 10'h364;
        default: band_mhz <= 10'h394;
      endcase
      // Six bits, since the top trim code reaches 32 half-picofarads
      crystal_trim_halfpf <= `TRIM_BASE_HALFPF + {2'b00, trim_code};
      // The unused code reports no deviation rather than a guess
      if (dev_code == `DEV_UNUSED) begin
        deviation_khz <= 8'h00;
      end else begin
        deviation_khz <= dev_prod[7:0];
      end
      attenuation_db <= pwr_prod[4:0];
      channel_high   <= mod_s ^ radio_setup[`POLARITY_BIT];
      if (ook_mode) begin
        amplifier_on <= pa_enable & mod_s;
      end else begin
        amplifier_on <= pa_enable;
      end
    end
  end

  // ==========================================
  // Host clock output
  wire hclk_tick;
  host_clock_div u_hclk (
    .sys_clk   (sys_clk),
    .sys_rst   (sys_rst),
    .enable    (power_control[`HOSTCLK_EN_BIT]),
    .rate_code (radio_setup[`CLKDIV_HI:`CLKDIV_LO]),
    .tick      (hclk_tick)
  );

  always @(posedge sys_clk) begin
    if (sys_rst) begin
      host_clock_tick <= 1'b0;
    end else begin
      host_clock_tick <= hclk_tick;
    end
  end
endmodule // command_registers

/* tb/host_model.sv */
`timescale 1ns/10ps
// ==========================================
// Host side of the serial command link
module host_model (
  input  wire  interrupt_request_n,
  output logic select_n,
  output logic serial_clock,
  output logic serial_data
);
  initial begin
    select_n     = 1'b1;
    serial_clock = 1'b0;
    serial_data  = 1'b0;
  end
  // Clock idles low outside frames; freed data flips so a stale bit is never read as good
  task automatic xfer(input logic [15:0] w, input int nb, input int nc,
                      output logic [15:0] rd);
    rd = 16'h0000;
    select_n = 1'b0;
    for (int i = 0; i < nc; i++) begin
      #200 serial_data = (i < nb) ? w[15-i] : ~serial_data;
      #200 serial_clock = 1'b1;
      #400 if (i >= 7 && i < 23) rd[22-i] = interrupt_request_n;
      serial_clock = 1'b0;
    end
    #200 serial_data = ~serial_data;
    #200 select_n = 1'b1;
    #800;
  endtask
endmodule // host_model

/* tb/command_registers_sva.sv */
`timescale 1ns/10ps
module command_registers_sva (
  input wire        sys_clk,
  input wire        sys_rst,
  input wire        select_n,
  input wire        interrupt_request_n,
  input wire [15:0] radio_setup,
  input wire [7:0]  amplifier_level,
  input wire [15:0] power_control,
  input wire        transmit_start,
  input wire [9:0]  band_mhz,
  input wire        host_clock_tick,
  input wire [5:0]  crystal_trim_halfpf,
  input wire [7:0]  deviation_khz,
  input wire [4:0]  attenuation_db,
  input wire        amplifier_on
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  // ==========================================
  // Sequences
  // Decoders lag the registers by one edge, so only settled values are judged
  sequence s_setup_settled;
    !$past(sys_rst) && !$past(sys_rst, 2) && $stable(radio_setup);
  endsequence
  sequence s_level_settled;
    !$past(sys_rst) && !$past(sys_rst, 2) && $stable(amplifier_level);
  endsequence
  // ==========================================
  // Assertions
  a_band_decode: assert property (s_setup_settled |-> band_mhz ==
    (radio_setup[12:11] == 2'h0 ? 10'h13b : radio_setup[12:11] == 2'h1 ? 10'h1b1 :
     radio_setup[12:11] == 2'h2 ? 10'h364 : 10'h394)) else $error("band decode wrong");
  a_trim_decode: assert property (s_setup_settled |->
    crystal_trim_halfpf == 6'h11 + radio_setup[7:4]) else $error("trim decode wrong");
  a_dev_decode: assert property (s_setup_settled |-> deviation_khz ==
    (radio_setup[2:0] == 3'h7 ? 8'h00 : 8'h1e * (radio_setup[2:0] + 3'h1)))
    else $error("deviation decode wrong");
  a_atten_decode: assert property (s_level_settled |->
    attenuation_db == 5'h03 * amplifier_level[2:0]) else $error("attenuation decode wrong");
  a_start_pulse: assert property (transmit_start |->
    !$past(select_n, 2) ##1 !transmit_start) else $error("send pulse wrong");
  a_setup_framed: assert property ($changed(radio_setup) && !$past(sys_rst) |->
    !$past(select_n, 2)) else $error("setup changed outside a frame");
  a_tick_full: assert property ((power_control[0] && radio_setup[10:8] == 3'h7) [*3]
    |-> host_clock_tick) else $error("fastest host clock missing");
  a_tick_off: assert property (!power_control[0] [*3] |-> !host_clock_tick)
    else $error("host clock while disabled");
  a_amp_off: assert property ((!power_control[3] && !power_control[6]) [*2]
    |-> !amplifier_on) else $error("amplifier on while disabled");
  a_irq_por: assert property ($fell(sys_rst) |-> ##1 !interrupt_request_n)
    else $error("power-on interrupt missing");
endmodule // command_registers_sva

bind command_registers command_registers_sva chk_u (.sys_clk, .sys_rst, .select_n,
  .interrupt_request_n, .radio_setup, .amplifier_level, .power_control, .transmit_start,
  .band_mhz, .host_clock_tick, .crystal_trim_halfpf, .deviation_khz, .attenuation_db,
  .amplifier_on);

/* tb/tb.sv */
`timescale 1ns/10ps
module tb;
  // ==========================================
  // Signals
  logic        sys_clk, sys_rst, modulation_pin, key_n, supply_low;
  wire         select_n, serial_clock, serial_data, interrupt_request_n;
  wire         transmit_start, host_clock_tick, channel_high, amplifier_on;
  wire  [15:0] radio_setup, channel_tuning, symbol_rate, key_inputs;
  wire  [15:0] sleep_clock_command, periodic_wakeup, supply_threshold, power_control;
  wire  [9:0]  band_mhz;
  wire  [7:0]  amplifier_level, deviation_khz;
  wire  [5:0]  crystal_trim_halfpf;
  wire  [4:0]  attenuation_db;
  logic [15:0] w, rd, n, snap;
  int          n_mismatch, checks_done, i;
  int          n_start = 0;
  logic [15:0] cnt [8] = '{16'h000c, 16'h000f, 16'h0014, 16'h0018, 16'h001e, 16'h0028,
                           16'h003c, 16'h0078};
  logic [7:0]  cmd [5] = '{8'hc2, 8'hc4, 8'hc8, 8'hca, 8'he0};

  command_registers dut_u (.sys_clk, .sys_rst, .select_n, .serial_clock, .serial_data,
    .modulation_pin, .key_n, .supply_low, .interrupt_request_n, .radio_setup,
    .amplifier_level, .channel_tuning, .symbol_rate, .key_inputs, .sleep_clock_command,
    .periodic_wakeup, .supply_threshold, .power_control, .transmit_start, .band_mhz,
    .host_clock_tick, .crystal_trim_halfpf, .deviation_khz, .attenuation_db,
    .channel_high, .amplifier_on);
  host_model host_u (.interrupt_request_n, .select_n, .serial_clock, .serial_data);

  // Send pulses are counted, so a missing, doubled or stray pulse shows up
  always @(posedge sys_clk) begin
    if (transmit_start) n_start <= n_start + 1;
  end

  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  // ==========================================
  // Helpers
  task automatic tick(input int k);
    repeat (k) @(posedge sys_clk);
    #1;
  endtask
  task automatic check(input logic [15:0] got, input logic [15:0] want);
    checks_done++;
    if (got !== want) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h want %h", $time, got, want);
    end
  endtask
  task automatic put(input logic [15:0] v, input int nb);
    host_u.xfer(v, nb, nb, rd);
    tick(2);
  endtask
  task automatic status(input logic [15:0] e, input logic irq);
    host_u.xfer(16'hcc00, 8, 23, rd);
    tick(4);
    check(rd, e);
    check(interrupt_request_n, irq);
  endtask
  function automatic logic [15:0] band_of(input logic [1:0] c);
    return (c == 2'h0) ? 16'h013b : (c == 2'h1) ? 16'h01b1 : (c == 2'h2) ? 16'h0364 : 16'h0394;
  endfunction
  function automatic logic [15:0] dev_of(input logic [2:0] c);
    return (c == 3'h7) ? 16'h0000 : 16'h001e * (c + 16'h0001);
  endfunction
  task automatic finish_test;
    $display("mismatches %0d checks %0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // ==========================================
  // Scenarios
  initial begin
    n_mismatch = 0;
    checks_done = 0;
    sys_rst = 1'b1;
    modulation_pin = 1'b0;
    key_n = 1'b1;
    supply_low = 1'b0;
    i = $urandom(32'h9cf29c90);
    tick(20);
    sys_rst = 1'b0;
    tick(4);
    check(radio_setup, 16'h8080);
    check(amplifier_level, 16'h00b0);
    check(power_control, 16'hc000);
    check(supply_threshold, 16'hc200);
    check(sleep_clock_command, 16'hc400);
    check(symbol_rate, 16'hc800);
    check(key_inputs, 16'hca00);
    check(periodic_wakeup, 16'he000);
    check(channel_tuning, 16'ha7d0);
    status(16'hc000, 1'b1);
    for (i = 0; i < 8; i++) begin
      w = {3'h4, 13'($urandom)};
      w[12:11] = i[1:0];
      w[2:0] = i[2:0];
      put(w, 16);
      modulation_pin = 1'($urandom);
      tick(5);
      check(radio_setup, w);
      check(band_mhz, band_of(w[12:11]));
      check(crystal_trim_halfpf, 16'h0011 + w[7:4]);
      check(deviation_khz, dev_of(w[2:0]));
      check(channel_high, modulation_pin ^ w[3]);
    end
    put(16'hc008, 16);
    for (i = 0; i < 16; i++) begin
      put({4'hb, i[3:0], 8'h00}, 8);
      modulation_pin = 1'($urandom);
      tick(5);
      check(amplifier_level, {8'h00, 4'hb, i[3:0]});
      check(attenuation_db, 16'h0003 * i[2:0]);
      check(amplifier_on, !i[3] || modulation_pin);
    end
    put(16'hc000, 16);
    put(16'hc002, 16);
    snap = radio_setup;
    put(16'h2abc, 16);
    put(16'hd5a5, 16);
    check(radio_setup, snap);
    check(power_control, 16'hc002);
    for (i = 0; i < 5; i++) begin
      w = {cmd[i], 8'($urandom)};
      if (i == 4) w[12:0] = 13'($urandom);
      put(w, 16);
      snap = (i == 0) ? supply_threshold : (i == 1) ? sleep_clock_command :
             (i == 2) ? symbol_rate : (i == 3) ? key_inputs : periodic_wakeup;
      check(snap, w);
    end
    check(16'(n_start), 16'h0000);
    put(16'hc600, 16);
    check(16'(n_start), 16'h0001);
    // Tuning words below 96 or above 3903 must leave the last good value
    put(16'ha05f, 16);
    put(16'ha060, 16);
    put(16'haf40, 16);
    check(channel_tuning, 16'ha060);
    put(16'hc001, 16);
    for (i = 0; i < 8; i++) begin
      put({5'h10, i[2:0], 8'h80}, 16);
      tick(5);
      n = 16'h0000;
      repeat (120) begin
        tick(1);
        n = n + host_clock_tick;
      end
      check(n, cnt[i]);
    end
    key_n = 1'b0;
    tick(8);
    key_n = 1'b1;
    supply_low = 1'b1;
    tick(8);
    status(16'h7000, 1'b0);
    status(16'h5000, 1'b1);
    check(16'(n_start), 16'h0001);
    finish_test;
  end

  initial begin
    #3000000;
    n_mismatch++;
    finish_test;
  end
endmodule // tb
